// File: design/etc_exc_ctrl.sv
// Machine-check exception delivery and shutdown controller.
`default_nettype none
module etc_exc_ctrl
   import etc_pkg::*;
(
   input  wire logic clk_in,       // Core clock.
   input  wire logic sys_rst_in,   // Synchronous reset.
   input  wire logic exc_en_in,    // Exception enable from control register 4.
   input  wire logic uc_err_in,    // Uncorrectable error event.
   input  wire logic cip_clr_in,   // Software clears check in progress.
   output logic      deliver_out,  // Pulse: transfer to handler.
   output logic      cip_out,      // Check in progress flag.
   output logic      shutdown_out  // Shutdown state.
);
   etc_exc_state_t state_reg;
   // A second exception while a check is in progress shuts the core down.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= ETC_RUN;
      end else begin
         case (state_reg)
            ETC_RUN, ETC_DELIVER: begin
               if (uc_err_in && exc_en_in && cip_out) begin
                  state_reg <= ETC_SHUTDOWN;
               end else if (uc_err_in && exc_en_in) begin
                  state_reg <= ETC_DELIVER;
               end else begin
                  state_reg <= ETC_RUN;
               end
            end
            ETC_SHUTDOWN: state_reg <= ETC_SHUTDOWN;
            default:      state_reg <= ETC_RUN;
         endcase
      end
   end
   // Set wins over the software clear so no exception goes unmarked.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cip_out <= 1'b0;
      end else if (uc_err_in && exc_en_in && !cip_out) begin
         cip_out <= 1'b1;
      end else if (cip_clr_in) begin
         cip_out <= 1'b0;
      end
   end
   assign deliver_out  = (state_reg == ETC_DELIVER);
   assign shutdown_out = (state_reg == ETC_SHUTDOWN);
endmodule // etc_exc_ctrl
`default_nettype wire

// File: design/etc_pkg.sv
// Package of constants and types for the error threshold counter block.
`default_nettype none
package etc_pkg;
   // ****************************************************************
   // Threshold register field positions
   // ****************************************************************
   localparam int unsigned ETC_RGOOD_BIT   = 63;
   localparam int unsigned ETC_CPRES_BIT   = 62;
   localparam int unsigned ETC_LOCK_BIT    = 61;
   localparam int unsigned ETC_VOFF_HI     = 55;
   localparam int unsigned ETC_VOFF_LO     = 52;
   localparam int unsigned ETC_CNTEN_BIT   = 51;
   localparam int unsigned ETC_ITYPE_HI    = 50;
   localparam int unsigned ETC_ITYPE_LO    = 49;
   localparam int unsigned ETC_OVF_BIT     = 48;
   localparam int unsigned ETC_CNT_HI      = 47;
   localparam int unsigned ETC_CNT_LO      = 32;
   localparam int unsigned ETC_BPTR_HI     = 31;
   localparam int unsigned ETC_BPTR_LO     = 24;
   // ****************************************************************
   // Addresses and reset values
   // ****************************************************************
   localparam logic [11:0] ETC_VEC_BASE    = 12'h500;
   localparam logic [31:0] ETC_XBLK_BASE   = 32'hC0000400;
   localparam logic [3:0]  ETC_VOFF_RST    = 4'h0;
   localparam logic [1:0]  ETC_ITYPE_RST   = 2'h0;
   localparam logic [1:0]  ETC_ITYPE_NONE  = 2'h0;
   localparam logic [1:0]  ETC_ITYPE_LIC   = 2'h1;
   localparam int unsigned ETC_FEAT_EXC    = 7;
   localparam int unsigned ETC_FEAT_REGS   = 14;
   localparam int unsigned ETC_CR4_EXC_BIT = 6;
   localparam logic [7:0]  ETC_BANKS_RST   = 8'h05;
   // ****************************************************************
   // Exception delivery states
   // ****************************************************************
   typedef enum logic [2:0] {
      ETC_RUN      = 3'b001,
      ETC_DELIVER  = 3'b010,
      ETC_SHUTDOWN = 3'b100
   } etc_exc_state_t;
endpackage : etc_pkg
`default_nettype wire

// File: design/etc_sat_counter.sv
// Saturating error counter with selectable implemented width.
`default_nettype none
module etc_sat_counter
   import etc_pkg::*;
#(
   parameter int unsigned CNT_W = 16
) (
   input  wire logic        clk_in,      // Core clock.
   input  wire logic        cold_rst_in, // Cold reset clears, warm reset does not.
   input  wire logic        inc_in,      // One logged error.
   input  wire logic        load_in,     // Software load.
   input  wire logic [15:0] load_val_in, // Software value.
   output logic      [15:0] count_out,   // Counter, unimplemented bits zero.
   output logic             step_max_out // Pulse on step into maximum.
);
   logic [CNT_W-1:0] cnt_reg;
   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   // Count only below maximum so the value never wraps; a load wins over an error.
   always_ff @(posedge clk_in) begin
      if (cold_rst_in) begin
         cnt_reg <= '0;
      end else if (load_in) begin
         cnt_reg <= load_val_in[CNT_W-1:0];
      end else if (inc_in && cnt_reg != CNT_MAX) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
   // Step pulse marks the transition from max-1 to max.
   always_ff @(posedge clk_in) begin
      if (cold_rst_in) begin
         step_max_out <= 1'b0;
      end else begin
         step_max_out <= !load_in && inc_in && (cnt_reg == CNT_MAX - 1'b1);
      end
   end
   // Upper bits read as zero when the counter is narrower.
   assign count_out = 16'(cnt_reg);
endmodule // etc_sat_counter
`default_nettype wire

// File: design/etc_top.sv
// Error threshold register bank with exception control, top level.
//
// Overview of operation
// - Bit 63 marks present flag and pointer valid.
// - Bit 62 reports a physical counter.
// - Locked flag drops writes to bits 60:0.
// - Lock writable only with status write enable.
// - Offset selects vector entry at offset*16+500h.
// - Count only while count enable set.
// - Type field: 00 none, 01 controller interrupt.
// - Overflow set stepping into max, raises interrupt.
// - Overflow and counter survive warm reset.
// - Unimplemented counter bits read zero.
// - Increment per logged error, saturate at max.
// - Block pointer locates extra register, same everywhere.
// - Reset clears all reporting enables.
// - Exception during check in progress shuts down.
// - Banks numbered zero to count minus one.
// - Identify reports bits 7 and 14.
// - Deliver exceptions only when enable bit set.
// - Uncorrectable error transfers control immediately.
`default_nettype none
module etc_top
   import etc_pkg::*;
#(
   parameter int unsigned CNT_W     = 16,        // Implemented counter width.
   parameter logic [7:0]  BLK_PTR   = 8'h00,     // Extra block pointer.
   parameter logic        CNT_PRES  = 1'b1,      // Counter physically present.
   parameter logic [7:0]  BANK_CNT  = ETC_BANKS_RST, // Number of banks.
   parameter logic [7:0]  BANK_IDX  = 8'h00      // This bank's number.
) (
   input  wire logic        clk_in,          // Core clock, 10 MHz.
   input  wire logic        sys_rst_in,      // Synchronous reset, warm or cold.
   input  wire logic        cold_rst_in,     // Cold reset qualifier.
   input  wire logic        wr_in,           // Register write strobe.
   input  wire logic [63:0] wr_data_in,      // Register write data.
   input  wire logic        status_wen_in,   // Status write enable config bit.
   input  wire logic        err_logged_in,   // Logged error of this source.
   input  wire logic        uc_err_in,       // Uncorrectable error event.
   input  wire logic        cr4_exc_en_in,   // Exception enable bit.
   input  wire logic        cip_clr_in,      // Software clears check in progress.
   input  wire logic [7:0]  rpt_en_in,       // Reporting enables written by software.
   input  wire logic        rpt_en_wr_in,    // Reporting enable write strobe.
   output logic      [63:0] rd_data_out,     // Threshold register read value.
   output logic             irq_out,         // Threshold interrupt pulse.
   output logic      [11:0] vec_addr_out,    // Selected vector entry address.
   output logic      [31:0] xblk_addr_out,   // Extra threshold register address.
   output logic      [7:0]  rpt_en_out,      // Reporting enables.
   output logic      [7:0]  bank_max_out,    // Highest bank number.
   output logic      [31:0] feature_out,     // Identify feature register.
   output logic             exc_deliver_out, // Transfer to exception handler.
   output logic             cip_out,         // Check in progress.
   output logic             shutdown_out     // Shutdown state.
);
   // ****************************************************************
   // Configuration fields
   // ****************************************************************
   logic        lock_reg;
   logic [3:0]  voff_reg;
   logic        cnten_reg;
   logic [1:0]  itype_reg;
   logic        ovf_reg;
   logic [15:0] count;
   logic        step_max;
   logic        sw_wr;
   logic        deliver;
   logic        cip;
   logic        shut;

   // Writes below the lock bit are dropped silently while locked.
   assign sw_wr = wr_in && !lock_reg;

   // Lock bit only follows software when the config enable allows it.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lock_reg <= 1'b0;
      end else if (wr_in && status_wen_in) begin
         lock_reg <= wr_data_in[ETC_LOCK_BIT];
      end
   end

   // Configuration fields clear on any reset.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         voff_reg  <= ETC_VOFF_RST;
         cnten_reg <= 1'b0;
         itype_reg <= ETC_ITYPE_RST;
      end else if (sw_wr) begin
         voff_reg  <= wr_data_in[ETC_VOFF_HI:ETC_VOFF_LO];
         cnten_reg <= wr_data_in[ETC_CNTEN_BIT];
         itype_reg <= wr_data_in[ETC_ITYPE_HI:ETC_ITYPE_LO];
      end
   end

   // ****************************************************************
   // Counter and overflow
   // ****************************************************************
   // Only cold reset clears the counter, so errors seen before a warm reset persist.
   etc_sat_counter #(
      .CNT_W (CNT_W)
   ) u_cnt (
      .clk_in       (clk_in),
      .cold_rst_in  (cold_rst_in),
      .inc_in       (err_logged_in && cnten_reg && CNT_PRES),
      .load_in      (sw_wr),
      .load_val_in  (wr_data_in[ETC_CNT_HI:ETC_CNT_LO]),
      .count_out    (count),
      .step_max_out (step_max)
   );

   // Hardware set wins over a software write of zero in the same cycle.
   always_ff @(posedge clk_in) begin
      if (cold_rst_in) begin
         ovf_reg <= 1'b0;
      end else if (step_max) begin
         ovf_reg <= 1'b1;
      end else if (sw_wr) begin
         ovf_reg <= wr_data_in[ETC_OVF_BIT];
      end
   end

   // Interrupt when a step into maximum sets a clear overflow flag, only for the controller type.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= step_max && !ovf_reg && (itype_reg == ETC_ITYPE_LIC);
      end
   end

   // ****************************************************************
   // Read path and derived addresses
   // ****************************************************************
   // Reserved fields read as zero; the valid flag is fixed since both fields are constant.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= 64'h0;
      end else begin
         rd_data_out <= '0;
         rd_data_out[ETC_RGOOD_BIT] <= 1'b1;
         rd_data_out[ETC_CPRES_BIT] <= CNT_PRES;
         rd_data_out[ETC_LOCK_BIT]  <= lock_reg;
         rd_data_out[ETC_VOFF_HI:ETC_VOFF_LO]   <= voff_reg;
         rd_data_out[ETC_CNTEN_BIT]             <= cnten_reg;
         rd_data_out[ETC_ITYPE_HI:ETC_ITYPE_LO] <= itype_reg;
         rd_data_out[ETC_OVF_BIT]               <= ovf_reg;
         rd_data_out[ETC_CNT_HI:ETC_CNT_LO]     <= count;
         rd_data_out[ETC_BPTR_HI:ETC_BPTR_LO]   <= BLK_PTR;
      end
   end

   // Addresses are registered so the outputs come straight from flops.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         vec_addr_out  <= 12'h0;
         xblk_addr_out <= 32'h0;
      end else begin
         vec_addr_out  <= {4'h0, voff_reg, 4'h0} + ETC_VEC_BASE;
         xblk_addr_out <= (BLK_PTR != 8'h00) ? ({21'h0, BLK_PTR, 3'h0} + ETC_XBLK_BASE) : 32'h0;
      end
   end

   // ****************************************************************
   // Global machine-check state
   // ****************************************************************
   // Reporting enables start cleared after every reset.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rpt_en_out <= 8'h00;
      end else if (rpt_en_wr_in) begin
         rpt_en_out <= rpt_en_in;
      end
   end

   // Constant capability words; registered to keep outputs flop-driven.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         bank_max_out <= 8'h00;
         feature_out  <= 32'h0;
      end else begin
         bank_max_out <= BANK_CNT - 8'h01;
         feature_out  <= (32'h1 << ETC_FEAT_EXC) | (32'h1 << ETC_FEAT_REGS);
      end
   end

   etc_exc_ctrl u_exc (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .exc_en_in    (cr4_exc_en_in),
      .uc_err_in    (uc_err_in),
      .cip_clr_in   (cip_clr_in),
      .deliver_out  (deliver),
      .cip_out      (cip),
      .shutdown_out (shut)
   );

   // Exception outputs, one cycle behind the controller.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         exc_deliver_out <= 1'b0;
         cip_out         <= 1'b0;
         shutdown_out    <= 1'b0;
      end else begin
         exc_deliver_out <= deliver;
         cip_out         <= cip;
         shutdown_out    <= shut;
      end
   end
endmodule // etc_top
`default_nettype wire

// File: tb/etc_top_bench.sv
// Self-checking testbench for the error threshold counter top level.
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
module etc_top_bench
   import etc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, sys_rst_in, cold_rst_in, wr_in, status_wen_in, err_logged_in;
   logic uc_err_in, cr4_exc_en_in, cip_clr_in, rpt_en_wr_in;
   logic [63:0] wr_data_in, rd_data_out;
   logic [7:0]  rpt_en_in, rpt_en_out, bank_max_out;
   logic [11:0] vec_addr_out;
   logic [31:0] xblk_addr_out, feature_out;
   logic irq_out, exc_deliver_out, cip_out, shutdown_out;
   int errors, num_checks;
   // Four-state counts so that an unknown pulse output shows up in the compare.
   logic [3:0] v, nirq, ndel;
   etc_top #(.BLK_PTR(8'h12)) etc_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cold_rst_in(cold_rst_in),
      .wr_in(wr_in), .wr_data_in(wr_data_in), .status_wen_in(status_wen_in), .err_logged_in(err_logged_in),
      .uc_err_in(uc_err_in), .cr4_exc_en_in(cr4_exc_en_in), .cip_clr_in(cip_clr_in), .rpt_en_in(rpt_en_in),
      .rpt_en_wr_in(rpt_en_wr_in), .rd_data_out(rd_data_out), .irq_out(irq_out), .vec_addr_out(vec_addr_out),
      .xblk_addr_out(xblk_addr_out), .rpt_en_out(rpt_en_out), .bank_max_out(bank_max_out),
      .feature_out(feature_out), .exc_deliver_out(exc_deliver_out), .cip_out(cip_out), .shutdown_out(shutdown_out));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Writable fields only; the read-only top bits and pointer are added by ex.
   function automatic logic [63:0] mk(logic l, logic [3:0] vo, logic c, logic [1:0] t, logic o, logic [15:0] n);
      return {2'b00, l, 5'h00, vo, c, t, o, n, 32'h0};
   endfunction
   function automatic logic [63:0] ex(logic [63:0] x);
      return x | {2'b11, 30'h0, 8'h12, 24'h0};
   endfunction
   task automatic rst(input logic cold);
      @(posedge clk_in) {sys_rst_in, cold_rst_in} <= {1'b1, cold};
      repeat (5) @(posedge clk_in);
      {sys_rst_in, cold_rst_in} <= 2'b00;
      repeat (3) @(posedge clk_in);
      #1;
   endtask
   // Result reads back two cycles after the write edge.
   task automatic wr(input logic [63:0] d);
      @(posedge clk_in) {wr_in, wr_data_in} <= {1'b1, d};
      @(posedge clk_in) wr_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   // One-cycle event pulse, then count the single-cycle answers for four cycles.
   task automatic ev(input int k);
      @(posedge clk_in) {rpt_en_wr_in, cip_clr_in, uc_err_in, err_logged_in} <= 4'(1 << k);
      @(posedge clk_in) {rpt_en_wr_in, cip_clr_in, uc_err_in, err_logged_in} <= 4'h0;
      nirq = 4'h0;
      ndel = 4'h0;
      repeat (4) @(posedge clk_in) begin
         #1;
         nirq = nirq + 4'(irq_out);
         ndel = ndel + 4'(exc_deliver_out);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge clk_in);
      errors++;
      stop_test();
   end
   initial begin
      {sys_rst_in, cold_rst_in, wr_in, status_wen_in, err_logged_in, uc_err_in} = 6'h30;
      {cr4_exc_en_in, cip_clr_in, rpt_en_wr_in, rpt_en_in, wr_data_in} = '0;
      rst(1'b1);
      `CHK(rpt_en_out, 8'h00)
      `CHK({feature_out[14], feature_out[7]}, 2'b11)
      `CHK(bank_max_out, 8'h04)
      `CHK(xblk_addr_out, 32'hC0000490)
      `CHK(rd_data_out[63:62], 2'b11)
      // Each of the four type encodings is written with its own vector offset while counting stays disabled.
      for (int t = 0; t < 4; t++) begin
         v = 4'hF - 4'(t * 5);
         wr(mk(1'b0, v, 1'b0, 2'(t), 1'b0, 16'h0));
         `CHK(rd_data_out, ex(mk(1'b0, v, 1'b0, 2'(t), 1'b0, 16'h0)))
         `CHK(vec_addr_out, {v, 4'h0} + 12'h500)
      end
      wr(mk(1'b0, 4'h0, 1'b0, 2'h1, 1'b0, 16'h1234));
      repeat (3) ev(0);
      `CHK(rd_data_out[47:32], 16'h1234)
      // Preload two errors short of the full-width threshold.
      wr(mk(1'b0, 4'h0, 1'b1, 2'h1, 1'b0, 16'hFFFD));
      ev(0);
      `CHK(nirq, 4'h0)
      ev(0);
      `CHK(nirq, 4'h1)
      `CHK(rd_data_out[48:32], 17'h1FFFF)
      ev(0);
      `CHK(nirq, 4'h0)
      `CHK(rd_data_out[47:32], 16'hFFFF)
      wr(mk(1'b0, 4'h0, 1'b1, 2'h0, 1'b0, 16'hFFFE));
      ev(0);
      `CHK(nirq, 4'h0)
      `CHK(rd_data_out[48], 1'b1)
      rst(1'b0);
      `CHK(rd_data_out, ex(mk(1'b0, 4'h0, 1'b0, 2'h0, 1'b1, 16'hFFFF)))
      rst(1'b1);
      `CHK(rd_data_out[48:32], 17'h0)
      @(posedge clk_in) status_wen_in <= 1'b1;
      wr(mk(1'b1, 4'h3, 1'b0, 2'h0, 1'b0, 16'h0005));
      @(posedge clk_in) status_wen_in <= 1'b0;
      wr(mk(1'b0, 4'h9, 1'b1, 2'h1, 1'b0, 16'h0007));
      `CHK(rd_data_out, ex(mk(1'b1, 4'h3, 1'b0, 2'h0, 1'b0, 16'h0005)))
      // The unlocking write still meets the lock, so only the lock bit changes.
      @(posedge clk_in) status_wen_in <= 1'b1;
      wr(mk(1'b0, 4'h9, 1'b1, 2'h1, 1'b0, 16'h0007));
      `CHK(rd_data_out, ex(mk(1'b0, 4'h3, 1'b0, 2'h0, 1'b0, 16'h0005)))
      wr(mk(1'b0, 4'h9, 1'b1, 2'h1, 1'b0, 16'h0007));
      `CHK(rd_data_out, ex(mk(1'b0, 4'h9, 1'b1, 2'h1, 1'b0, 16'h0007)))
      ev(1);
      `CHK(ndel, 4'h0)
      @(posedge clk_in) cr4_exc_en_in <= 1'b1;
      ev(1);
      `CHK(ndel, 4'h1)
      `CHK(cip_out, 1'b1)
      ev(2);
      `CHK(cip_out, 1'b0)
      ev(1);
      ev(1);
      `CHK(shutdown_out, 1'b1)
      `CHK(ndel, 4'h0)
      @(posedge clk_in) rpt_en_in <= 8'hA5;
      ev(3);
      `CHK(rpt_en_out, 8'hA5)
      rst(1'b0);
      `CHK(rpt_en_out, 8'h00)
      `CHK(shutdown_out, 1'b0)
      stop_test();
   end
endmodule // etc_top_bench
bind etc_top etc_top_props #(.BANK_CNT(BANK_CNT)) etc_top_props_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .wr_in(wr_in), .status_wen_in(status_wen_in), .err_logged_in(err_logged_in), .uc_err_in(uc_err_in),
   .cr4_exc_en_in(cr4_exc_en_in), .cip_clr_in(cip_clr_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
   .vec_addr_out(vec_addr_out), .bank_max_out(bank_max_out), .feature_out(feature_out),
   .exc_deliver_out(exc_deliver_out), .cip_out(cip_out), .shutdown_out(shutdown_out));
`default_nettype wire

// File: tb/etc_top_props.sv
// Assertion checker for the error threshold counter top level.
`default_nettype none
module etc_top_props
   import etc_pkg::*;
#(
   parameter logic [7:0] BANK_CNT = 8'h05 // Number of banks.
) (
   input wire logic        clk_in,          // Core clock.
   input wire logic        sys_rst_in,      // Synchronous reset.
   input wire logic        wr_in,           // Write strobe.
   input wire logic        status_wen_in,   // Lock write enable.
   input wire logic        err_logged_in,   // Logged error.
   input wire logic        uc_err_in,       // Uncorrectable error.
   input wire logic        cr4_exc_en_in,   // Exception enable.
   input wire logic        cip_clr_in,      // Check flag clear.
   input wire logic [63:0] rd_data_out,     // Register read value.
   input wire logic        irq_out,         // Threshold interrupt.
   input wire logic [11:0] vec_addr_out,    // Vector entry address.
   input wire logic [7:0]  bank_max_out,    // Highest bank number.
   input wire logic [31:0] feature_out,     // Feature register.
   input wire logic        exc_deliver_out, // Handler transfer.
   input wire logic        cip_out,         // Check in progress.
   input wire logic        shutdown_out     // Shutdown state.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] since_rst;
   logic       up;
   // ****************************************************************
   // Settle counter: outputs may read zero just after reset ends.
   // ****************************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) since_rst <= 3'h0;
      else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
   end
   assign up = (since_rst == 3'h7);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   feature_bits_a: assert property (up |-> feature_out[14] && feature_out[7])
      else $error("feature bits missing");
   bank_max_a: assert property (up |-> bank_max_out == BANK_CNT - 8'h01)
      else $error("bank number range wrong");
   vec_addr_a: assert property ((up && $stable(rd_data_out[55:52]))[*3] |->
      vec_addr_out == {rd_data_out[55:52], 4'h0} + 12'h500) else $error("vector address wrong");
   // The read word shows overflow one cycle after the interrupt pulse, since both are registered.
   irq_cause_a: assert property (irq_out |-> $past(err_logged_in, 2) ##1 rd_data_out[48])
      else $error("interrupt without overflow step");
   count_hold_a: assert property ((up && !rd_data_out[51] && !wr_in)[*3] |=> $stable(rd_data_out[47:32]))
      else $error("counter moved while disabled");
   saturate_a: assert property (!wr_in ##1 (!wr_in && rd_data_out[47:32] == 16'hFFFF) |=>
      rd_data_out[47:32] == 16'hFFFF) else $error("counter wrapped");
   lock_drop_a: assert property (!wr_in ##1 (wr_in && rd_data_out[61] && !status_wen_in) |=>
      ##1 $stable(rd_data_out[55:49])) else $error("locked write took effect");
   lock_guard_a: assert property (!wr_in ##1 (wr_in && !status_wen_in) |=> ##1 $stable(rd_data_out[61]))
      else $error("lock changed without enable");
   deliver_cause_a: assert property (exc_deliver_out |-> $past(uc_err_in, 2) && $past(cr4_exc_en_in, 2) && cip_out)
      else $error("exception delivered without cause");
   // The visible check flag lags the internal one, so a clear in the cycle before must be excluded.
   nested_exc_a: assert property (uc_err_in && cip_out && cr4_exc_en_in && !cip_clr_in && !$past(cip_clr_in)
      |-> ##2 shutdown_out) else $error("nested exception did not shut down");
   shutdown_stay_a: assert property (shutdown_out |=> shutdown_out)
      else $error("shutdown left without reset");
   irq_seen_c: cover property (irq_out);
   deliver_seen_c: cover property (exc_deliver_out);
   shutdown_seen_c: cover property ($rose(shutdown_out));
endmodule // etc_top_props
`default_nettype wire
